// ### inc/sram_host_pkg.sv
// Purpose: constants and carrier types for the async SRAM host controller
// Assumes: 50 MHz system clock, 20 ns period
// Notes: times in ns, cycle counts derived by rounding
package sram_host_pkg;
	localparam int CLK_NS = 20;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	// Printed times in ns
	localparam int T_RC_NS = 45;
	localparam int T_AA_NS = 45;
	localparam int T_WC_NS = 45;
	localparam int T_PWE_NS = 35;
	localparam int T_SD_NS = 25;
	localparam int T_AW_NS = 35;
	localparam int T_HZ_NS = 18;
	// Least times round up; settle times treated as least waits
	localparam int RD_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWE_CYC_A = (T_PWE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SD_CYC = (T_SD_NS + CLK_NS - 1) / CLK_NS;
	localparam int AW_CYC = (T_AW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
	localparam int HZ_CYC = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_MAX1 = (PWE_CYC_A > SD_CYC) ? PWE_CYC_A : SD_CYC;
	localparam int WP_CYC = (WP_MAX1 > AW_CYC) ? WP_MAX1 : AW_CYC;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_CYC);
	localparam logic [CNT_W-1:0] WP_WAIT = CNT_W'(WP_CYC);
	localparam logic [CNT_W-1:0] RC_WAIT = CNT_W'(RC_CYC);
	localparam logic [CNT_W-1:0] WC_WAIT = CNT_W'(WC_CYC);
	localparam logic [CNT_W-1:0] HZ_WAIT = CNT_W'(HZ_CYC);

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RD_WAIT = 3'h1,
		ST_RD_END = 3'h2,
		ST_WR_SETUP = 3'h3,
		ST_WR_PULSE = 3'h4,
		ST_WR_END = 3'h5,
		ST_TURN = 3'h6
	} host_state_t;

	typedef struct packed {
		logic chip_select_n;
		logic chip_select_hi;
		logic write_n;
		logic out_en_n;
		logic upper_lane_sel_n;
		logic lower_lane_sel_n;
	} sram_ctl_t;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] lane_n;
	} host_req_t;

	localparam sram_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// ### design/reset_sync.sv
// Purpose: two-flop release of the active-low reset
// Assumes: rstn is asynchronous
// Notes: assertion is immediate, release is clocked
`timescale 1ns/1ns
module reset_sync (
	input wire logic sys_clk,
	input wire logic rstn,
	output logic rst_n_sync
);
	logic [1:0] sync_ff;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync_ff <= 2'h0;
		end else begin
			sync_ff <= {sync_ff[0], 1'b1};
		end
	end
	assign rst_n_sync = sync_ff[1];
endmodule

// ### design/sram_host.sv
// Purpose: host controller driving an async 16-bit SRAM by its pins
// Assumes: one request at a time, pins sampled in the sys_clk domain
// Notes: write is strobe controlled; selects frame the whole cycle
`timescale 1ns/1ns
module sram_host
	import sram_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire host_req_t req,
	output logic req_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic wr_done,
	output sram_ctl_t sram_ctl,
	output logic [ADDR_W-1:0] sram_addr,
	output logic [DATA_W-1:0] sram_dq_out,
	output logic sram_dq_oe,
	input wire logic [DATA_W-1:0] sram_dq_in
);
	typedef struct packed {
		host_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] cyc;
		logic is_write;
		logic ready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic wdone;
		sram_ctl_t ctl;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} host_reg_t;

	logic rst_n;
	host_reg_t state_ff;
	host_reg_t nxt_state;

	reset_sync u_reset_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.rst_n_sync(rst_n)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.rvalid = 1'b0;
		nxt_state.wdone = 1'b0;
		if (state_ff.cyc != CNT_ZERO) begin
			nxt_state.cyc = state_ff.cyc - CNT_ONE;
		end
		case (state_ff.st)
			ST_IDLE: begin
				if (req_valid && state_ff.ready) begin
					nxt_state.ready = 1'b0;
					// Address changes on the same edge that the selects go active
					nxt_state.addr = req.addr;
					nxt_state.is_write = req.write;
					nxt_state.ctl.chip_select_n = 1'b0;
					nxt_state.ctl.chip_select_hi = 1'b1;
					nxt_state.ctl.upper_lane_sel_n = req.lane_n[1];
					nxt_state.ctl.lower_lane_sel_n = req.lane_n[0];
					nxt_state.ctl.write_n = 1'b1;
					nxt_state.cyc = req.write ? WC_WAIT : RC_WAIT;
					if (req.write) begin
						nxt_state.dq = req.wdata;
						nxt_state.ctl.out_en_n = 1'b1;
						nxt_state.st = ST_WR_SETUP;
					end else begin
						nxt_state.ctl.out_en_n = 1'b0;
						nxt_state.cnt = RD_WAIT;
						nxt_state.st = ST_RD_WAIT;
					end
				end
			end
			ST_RD_WAIT: begin
				// Access time counted from select, address and enable
				if (state_ff.cnt == CNT_ONE) begin
					nxt_state.st = ST_RD_END;
				end else begin
					nxt_state.cnt = state_ff.cnt - CNT_ONE;
				end
			end
			ST_RD_END: begin
				nxt_state.rdata = sram_dq_in;
				nxt_state.rvalid = 1'b1;
				// Deselect before address moves, so old data is irrelevant
				nxt_state.ctl = CTL_IDLE;
				nxt_state.cnt = HZ_WAIT;
				nxt_state.st = ST_TURN;
			end
			ST_WR_SETUP: begin
				// Pins already quiet: output enable was never low here
				nxt_state.dq_oe = 1'b1;
				nxt_state.ctl.write_n = 1'b0;
				nxt_state.cnt = WP_WAIT;
				nxt_state.st = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				// Pulse covers strobe width, data setup and address setup
				if (state_ff.cnt == CNT_ONE) begin
					nxt_state.ctl.write_n = 1'b1;
					nxt_state.st = ST_WR_END;
				end else begin
					nxt_state.cnt = state_ff.cnt - CNT_ONE;
				end
			end
			ST_WR_END: begin
				// Data, address and selects outlive the strobe by a cycle
				nxt_state.dq_oe = 1'b0;
				nxt_state.ctl = CTL_IDLE;
				nxt_state.wdone = 1'b1;
				nxt_state.cnt = HZ_WAIT;
				nxt_state.st = ST_TURN;
			end
			ST_TURN: begin
				// Wait out release time and cycle spacing before next access
				if (state_ff.cnt != CNT_ZERO) begin
					nxt_state.cnt = state_ff.cnt - CNT_ONE;
				end else if (state_ff.cyc == CNT_ZERO) begin
					nxt_state.ready = 1'b1;
					nxt_state.st = ST_IDLE;
				end
			end
			default: begin
				nxt_state.st = ST_IDLE;
				nxt_state.ctl = CTL_IDLE;
				nxt_state.dq_oe = 1'b0;
				nxt_state.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '{st: ST_IDLE, ctl: CTL_IDLE, ready: 1'b1, default: '0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign req_ready = state_ff.ready;
	assign rd_valid = state_ff.rvalid;
	assign rd_data = state_ff.rdata;
	assign wr_done = state_ff.wdone;
	assign sram_ctl = state_ff.ctl;
	assign sram_addr = state_ff.addr;
	assign sram_dq_out = state_ff.dq;
	assign sram_dq_oe = state_ff.dq_oe;
endmodule

// ### test/sram_host_sva.sv
// Purpose: pin timing checks on the SRAM host
// Assumes: one clock, counts from the hand-over timing
// Notes: bound to every host instance
`timescale 1ns/1ns
module sram_host_chk
	import sram_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire host_req_t req,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic wr_done,
	input wire sram_ctl_t sram_ctl,
	input wire logic [ADDR_W-1:0] sram_addr,
	input wire logic [DATA_W-1:0] sram_dq_out,
	input wire logic sram_dq_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire w_n = sram_ctl.write_n;
	wire cs_on = !sram_ctl.chip_select_n && sram_ctl.chip_select_hi;
	wire ln_on = !(sram_ctl.upper_lane_sel_n && sram_ctl.lower_lane_sel_n);
	wr_sel_a: assert property ($fell(w_n) |-> $past(cs_on) && cs_on && (ln_on == $past(ln_on)))
		else $error("selects not ahead of strobe");
	pulse_a: assert property ($fell(w_n) |=> !w_n ##1 w_n)
		else $error("strobe width wrong");
	rd_we_a: assert property (!sram_ctl.out_en_n |-> w_n)
		else $error("strobe low in read");
	no_clash_a: assert property (!sram_ctl.out_en_n |-> !sram_dq_oe)
		else $error("host drives during read");
	addr_a: assert property (!w_n |-> $stable(sram_addr) ##1 $stable(sram_addr))
		else $error("address moved in write");
	data_a: assert property ($rose(w_n) |-> sram_dq_oe && $stable(sram_dq_out))
		else $error("data not held to write end");
	rd_lat_a: assert property (req_valid && req_ready && !req.write |-> ##5 rd_valid)
		else $error("read answer late");
	wr_end_a: assert property (wr_done |-> sram_ctl == CTL_IDLE && !sram_dq_oe)
		else $error("not released after write");
	gap_a: assert property ($fell(req_ready) |-> !req_ready [*5])
		else $error("cycles too close");
endmodule
bind sram_host sram_host_chk i_chk (.sys_clk, .rstn, .req_valid, .req, .req_ready,
	.rd_valid, .wr_done, .sram_ctl, .sram_addr, .sram_dq_out, .sram_dq_oe);

// ### test/sram_dev_model.sv
// Purpose: behavioural async SRAM facing the host
// Assumes: 256 words are enough here
// Notes: undriven lanes show the inverse word, never a held value
`timescale 1ns/1ns
module sram_dev_model
	import sram_host_pkg::*;
(
	input wire sram_ctl_t sram_ctl,
	input wire logic [ADDR_W-1:0] sram_addr,
	input wire logic [DATA_W-1:0] sram_dq_out,
	input wire logic sram_dq_oe,
	output logic [DATA_W-1:0] sram_dq_in
);
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] q, wd;
	logic [7:0] wa;
	logic [1:0] ln;
	wire sel = !sram_ctl.chip_select_n && sram_ctl.chip_select_hi;
	wire wr = sel && !sram_ctl.write_n && !(&{sram_ctl.upper_lane_sel_n, sram_ctl.lower_lane_sel_n});
	wire rd = sel && sram_ctl.write_n && !sram_ctl.out_en_n;
	wire #(10, 18) hi_on = rd && !sram_ctl.upper_lane_sel_n;
	wire #(10, 18) lo_on = rd && !sram_ctl.lower_lane_sel_n;
	// Transparent while writing, so only the last data before the end counts
	always @* if (wr) begin
		ln = {sram_ctl.upper_lane_sel_n, sram_ctl.lower_lane_sel_n};
		wa = sram_addr[7:0];
		wd = sram_dq_in;
	end
	always @(negedge wr) begin
		if (!ln[1]) mem[wa][15:8] = wd[15:8];
		if (!ln[0]) mem[wa][7:0] = wd[7:0];
		q <= #30 mem[sram_addr[7:0]];
	end
	always @(sram_addr) q <= #30 mem[sram_addr[7:0]];
	assign sram_dq_in = sram_dq_oe ? sram_dq_out :
		{hi_on ? q[15:8] : ~q[15:8], lo_on ? q[7:0] : ~q[7:0]};
endmodule

// ### test/sram_host_bench.sv
// Purpose: directed scenarios for the SRAM host
// Assumes: device model answers inside 60 ns
// Notes: one word per request
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module sram_host_bench
	import sram_host_pkg::*;
;
	logic sys_clk, rstn, req_valid, req_ready, rd_valid, wr_done, sram_dq_oe;
	host_req_t req;
	logic [DATA_W-1:0] rd_data, sram_dq_out, sram_dq_in, rdq;
	logic [ADDR_W-1:0] sram_addr;
	sram_ctl_t sram_ctl;
	int n_errors, checked, lat;
	logic [DATA_W-1:0] tbl [4] = '{16'h0001, 16'h8000, 16'hFFFF, 16'h5AA5};
	sram_host i_dut (.sys_clk, .rstn, .req_valid, .req, .req_ready, .rd_valid, .rd_data,
		.wr_done, .sram_ctl, .sram_addr, .sram_dq_out, .sram_dq_oe, .sram_dq_in);
	sram_dev_model i_mem (.sram_ctl, .sram_addr, .sram_dq_out, .sram_dq_oe, .sram_dq_in);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		$display("Errors %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] ln);
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b1;
		req <= '{wr, a, d, ln};
		@(posedge sys_clk);
		req_valid <= 1'b0;
		lat = 0;
		while ((wr ? wr_done : rd_valid) !== 1'b1 && lat < 20) begin
			@(posedge sys_clk);
			lat++;
		end
		rdq = rd_data;
		// Answer shows one edge after the design raises it
		`CHK("latency", wr ? WP_CYC + 3 : RD_CYC + 2, lat)
	endtask
	task automatic t_word();
		xfer(1'b1, 20'h0000A, 16'h1234, 2'h0);
		xfer(1'b0, 20'h0000A, 16'h0000, 2'h0);
		`CHK("word", 16'h1234, rdq)
	endtask
	task automatic t_lanes();
		xfer(1'b1, 20'h0000A, 16'hABCD, 2'h1);
		xfer(1'b1, 20'h0000A, 16'hFFFF, 2'h3);
		xfer(1'b0, 20'h0000A, 16'h0000, 2'h0);
		`CHK("upper lane", 16'hAB34, rdq)
		xfer(1'b0, 20'h0000A, 16'h0000, 2'h2);
		`CHK("lower only", 8'h34, rdq[7:0])
	endtask
	task automatic t_b2b();
		for (int i = 0; i < 4; i++) xfer(1'b1, 20'(i), tbl[i], 2'h0);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, 20'(i), 16'h0000, 2'h0);
			`CHK("burst", tbl[i], rdq)
		end
	endtask
	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		n_errors = 0;
		checked = 0;
		repeat (12) @(posedge sys_clk);
		`CHK("idle pins", CTL_IDLE, sram_ctl)
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_word();
		t_lanes();
		t_b2b();
		end_sim();
	end
	initial begin
		#20000;
		n_errors++;
		end_sim();
	end
endmodule
